/* File: hdl/msc_module_stop_ctrl.sv */
// module: module-stop control registers b and c with per-unit stop requests
`timescale 1ns/10ps

module msc_module_stop_ctrl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [msc_pkg::ADDR_W-1:0] regAddr,
   input wire logic [msc_pkg::DATA_W-1:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [msc_pkg::DATA_W-1:0] regRdData,
   input wire logic [msc_pkg::UNITS-1:0] unitAccessReq,
   output logic [msc_pkg::UNITS-1:0] unitAccessGrant,
   output logic pulseGenStop,
   output logic serial4Stop,
   output logic serial2Stop,
   output logic serial1Stop,
   output logic serial0Stop,
   output logic [msc_pkg::RAM_BANKS-1:0] ramBankStop
);
   // ------------------------------------------------------------
   // reset levels of the stop requests
   // ------------------------------------------------------------
   // taken from the register reset values so the two can never disagree
   localparam logic PULSE_GEN_RESET = msc_pkg::B_RESET[msc_pkg::BIT_PULSE_GEN];
   localparam logic SERIAL4_RESET = msc_pkg::B_RESET[msc_pkg::BIT_SERIAL4];
   localparam logic SERIAL2_RESET = msc_pkg::B_RESET[msc_pkg::BIT_SERIAL2];
   localparam logic SERIAL1_RESET = msc_pkg::B_RESET[msc_pkg::BIT_SERIAL1];
   localparam logic SERIAL0_RESET = msc_pkg::B_RESET[msc_pkg::BIT_SERIAL0];
   localparam logic [msc_pkg::RAM_BANKS-1:0] RAM_RESET =
      msc_pkg::C_RESET[msc_pkg::RAM_BANKS-1:0];

   // ------------------------------------------------------------
   // stored bits and decoded strobes
   // ------------------------------------------------------------
   logic [msc_pkg::DATA_W-1:0] stopB;
   logic [msc_pkg::DATA_W-1:0] stopC;
   logic [msc_pkg::DATA_W-1:0] next_stopB;
   logic [msc_pkg::DATA_W-1:0] next_stopC;
   logic [msc_pkg::DATA_W-1:0] wrViewB;
   logic [msc_pkg::DATA_W-1:0] wrViewC;
   logic [msc_pkg::DATA_W-1:0] rdViewB;
   logic [msc_pkg::DATA_W-1:0] rdViewC;
   logic [msc_pkg::DATA_W-1:0] next_rdData;
   logic next_pulseGenStop;
   logic next_serial4Stop;
   logic next_serial2Stop;
   logic next_serial1Stop;
   logic next_serial0Stop;
   logic [msc_pkg::RAM_BANKS-1:0] next_ramBankStop;
   logic [msc_pkg::UNITS-1:0] unitStopped;
   logic [msc_pkg::UNITS-1:0] next_grant;
   logic writeB;
   logic writeC;
   logic readB;
   logic readC;

   // ------------------------------------------------------------
   // address decoding
   // ------------------------------------------------------------
   // both sides decode the same word index, so one function per word keeps them in step
   function automatic logic hitsB(
      input logic [msc_pkg::ADDR_W-1:0] addr
   );
      logic hit;
      hit = 1'b0;
      if (addr == msc_pkg::ADDR_STOP_B) begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   function automatic logic hitsC(
      input logic [msc_pkg::ADDR_W-1:0] addr
   );
      logic hit;
      hit = 1'b0;
      if (addr == msc_pkg::ADDR_STOP_C) begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   // ------------------------------------------------------------
   // reserved-bit views
   // ------------------------------------------------------------
   // reserved bits of b are forced to 1, so a stray write of 0 cannot clear them
   function automatic logic [msc_pkg::DATA_W-1:0] viewB(
      input logic [msc_pkg::DATA_W-1:0] raw
   );
      logic [msc_pkg::DATA_W-1:0] view;
      view = raw | msc_pkg::B_FIXED_ONES;
      return view;
   endfunction

   // c keeps ones above and zeros in 7..3 whatever software writes
   function automatic logic [msc_pkg::DATA_W-1:0] viewC(
      input logic [msc_pkg::DATA_W-1:0] raw
   );
      logic [msc_pkg::DATA_W-1:0] view;
      view = (raw & msc_pkg::C_RAM_MASK) | msc_pkg::C_FIXED_ONES;
      return view;
   endfunction

   // ------------------------------------------------------------
   // strobes and views
   // ------------------------------------------------------------
   assign writeB = regWrite && hitsB(regAddr);
   assign writeC = regWrite && hitsC(regAddr);
   assign readB = regRead && hitsB(regAddr);
   assign readC = regRead && hitsC(regAddr);
   assign wrViewB = viewB(regWrData);
   assign wrViewC = viewC(regWrData);
   assign rdViewB = viewB(stopB);
   assign rdViewC = viewC(stopC);

   // ------------------------------------------------------------
   // register b
   // ------------------------------------------------------------
   always_comb begin
      next_stopB = stopB;
      if (writeB) begin
         next_stopB = wrViewB;
      end
   end

   // reset sets every bit: all peripherals start stopped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stopB <= msc_pkg::B_RESET;
      end else begin
         stopB <= next_stopB;
      end
   end

   // ------------------------------------------------------------
   // register c
   // ------------------------------------------------------------
   always_comb begin
      next_stopC = stopC;
      if (writeC) begin
         next_stopC = wrViewC;
      end
   end

   // only the bank field really varies: the rest is rebuilt by the view
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stopC <= msc_pkg::C_RESET;
      end else begin
         stopC <= next_stopC;
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   // unmapped words read as zero rather than echoing an old value
   always_comb begin
      if (readB) begin
         next_rdData = rdViewB;
      end else if (readC) begin
         next_rdData = rdViewC;
      end else begin
         next_rdData = msc_pkg::READ_UNMAPPED;
      end
   end

   // data stand for one cycle only, then fall back to zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= msc_pkg::READ_UNMAPPED;
      end else begin
         regRdData <= next_rdData;
      end
   end

   // ------------------------------------------------------------
   // stop requests
   // ------------------------------------------------------------
   // one flop per request gives the units a clean level; it costs one cycle
   always_comb begin
      next_pulseGenStop = stopB[msc_pkg::BIT_PULSE_GEN];
   end

   always_comb begin
      next_serial4Stop = stopB[msc_pkg::BIT_SERIAL4];
   end

   always_comb begin
      next_serial2Stop = stopB[msc_pkg::BIT_SERIAL2];
   end

   always_comb begin
      next_serial1Stop = stopB[msc_pkg::BIT_SERIAL1];
   end

   always_comb begin
      next_serial0Stop = stopB[msc_pkg::BIT_SERIAL0];
   end

   always_comb begin
      next_ramBankStop = stopC[msc_pkg::RAM_BANKS-1:0];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pulseGenStop <= PULSE_GEN_RESET;
      end else begin
         pulseGenStop <= next_pulseGenStop;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serial4Stop <= SERIAL4_RESET;
      end else begin
         serial4Stop <= next_serial4Stop;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serial2Stop <= SERIAL2_RESET;
      end else begin
         serial2Stop <= next_serial2Stop;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serial1Stop <= SERIAL1_RESET;
      end else begin
         serial1Stop <= next_serial1Stop;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serial0Stop <= SERIAL0_RESET;
      end else begin
         serial0Stop <= next_serial0Stop;
      end
   end

   // the bus master keeps a bank idle before stopping it; nothing here checks that
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ramBankStop <= RAM_RESET;
      end else begin
         ramBankStop <= next_ramBankStop;
      end
   end

   // ------------------------------------------------------------
   // unit map
   // ------------------------------------------------------------
   // grant bit order: pulse generator, serial 4, 2, 1, 0, then the banks
   assign unitStopped[msc_pkg::UNIT_PULSE_GEN] = pulseGenStop;
   assign unitStopped[msc_pkg::UNIT_SERIAL4] = serial4Stop;
   assign unitStopped[msc_pkg::UNIT_SERIAL2] = serial2Stop;
   assign unitStopped[msc_pkg::UNIT_SERIAL1] = serial1Stop;
   assign unitStopped[msc_pkg::UNIT_SERIAL0] = serial0Stop;

   genvar bank;
   generate
      for (bank = 0; bank < msc_pkg::RAM_BANKS; bank = bank + 1) begin : g_ramUnit
         assign unitStopped[msc_pkg::UNIT_RAM0 + bank] = ramBankStop[bank];
      end
   endgenerate

   // ------------------------------------------------------------
   // access gating
   // ------------------------------------------------------------
   // gating reads the registered stop level: a request in the cycle of the write still passes
   genvar unit;
   generate
      for (unit = 0; unit < msc_pkg::UNITS; unit = unit + 1) begin : g_gate
         assign next_grant[unit] = unitAccessReq[unit] && !unitStopped[unit];
      end
   endgenerate

   // a stopped unit is refused for as long as its request stays high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         unitAccessGrant <= '0;
      end else begin
         unitAccessGrant <= next_grant;
      end
   end
endmodule

/* File: pkg/msc_pkg.sv */
// package: register map, field positions and reset values of the module-stop block
package msc_pkg;
   // ------------------------------------------------------------
   // register map (word index on the plain register port)
   // ------------------------------------------------------------
   localparam int ADDR_W = 2;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] ADDR_STOP_B = 2'h0;
   localparam logic [ADDR_W-1:0] ADDR_STOP_C = 2'h1;
   localparam logic [DATA_W-1:0] READ_UNMAPPED = 16'h0000;
   // ------------------------------------------------------------
   // register b fields
   // ------------------------------------------------------------
   localparam int BIT_PULSE_GEN = 15;
   localparam int BIT_SERIAL4 = 12;
   localparam int BIT_SERIAL2 = 10;
   localparam int BIT_SERIAL1 = 9;
   localparam int BIT_SERIAL0 = 8;
   localparam logic [DATA_W-1:0] B_RESET = 16'hFFFF;
   localparam logic [DATA_W-1:0] B_FIXED_ONES = 16'h68FF;
   // ------------------------------------------------------------
   // register c fields
   // ------------------------------------------------------------
   localparam int RAM_BANKS = 3;
   localparam logic [DATA_W-1:0] C_RESET = 16'hFF00;
   localparam logic [DATA_W-1:0] C_FIXED_ONES = 16'hFF00;
   localparam logic [DATA_W-1:0] C_RAM_MASK = 16'h0007;
   // ------------------------------------------------------------
   // access window to gated modules
   // ------------------------------------------------------------
   localparam int UNITS = 8;
   localparam int UNIT_PULSE_GEN = 0;
   localparam int UNIT_SERIAL4 = 1;
   localparam int UNIT_SERIAL2 = 2;
   localparam int UNIT_SERIAL1 = 3;
   localparam int UNIT_SERIAL0 = 4;
   localparam int UNIT_RAM0 = 5;
endpackage

/* File: testbench/msc_properties.sv */
// checker: stop outputs, read data and access gating
`timescale 1ns/10ps
module msc_properties (
   input logic clk,
   input logic rst_n,
   input logic regWrite,
   input logic regRead,
   input logic [1:0] regAddr,
   input logic [15:0] regWrData,
   input logic [15:0] regRdData,
   input logic [7:0] unitAccessReq,
   input logic [7:0] unitAccessGrant,
   input logic pulseGenStop,
   input logic serial4Stop,
   input logic serial2Stop,
   input logic serial1Stop,
   input logic serial0Stop,
   input logic [2:0] ramBankStop
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire wb = regWrite && regAddr == 0;
   wire wc = regWrite && regAddr == 1;
   AST_PULSE: assert property (wb |-> ##2 pulseGenStop == $past(regWrData[15], 2))
      else $error("pulse stop wrong");
   AST_SER4: assert property (wb |-> ##2 serial4Stop == $past(regWrData[12], 2))
      else $error("serial4 stop wrong");
   AST_SER: assert property (wb |-> ##2 {serial2Stop, serial1Stop, serial0Stop} ==
      $past(regWrData[10:8], 2)) else $error("serial stop wrong");
   AST_RAM: assert property (wc |-> ##2 ramBankStop == $past(regWrData[2:0], 2))
      else $error("ram stop wrong");
   AST_RDB: assert property (regRead && regAddr == 0 |=> &(regRdData | 16'h9700))
      else $error("b reserved read wrong");
   AST_RDC: assert property (regRead && regAddr == 1 |=> regRdData[15:3] == 13'h1FE0)
      else $error("c reserved read wrong");
   AST_BLOCK: assert property (pulseGenStop [*3] |-> !unitAccessGrant[0])
      else $error("stopped unit granted");
   AST_HOLD: assert property (!$past(regWrite, 2) |-> $stable(ramBankStop))
      else $error("ram stop moved");
endmodule
bind msc_module_stop_ctrl msc_properties chk (.*);

/* File: testbench/msc_unit_model.sv */
// partner: peripherals and ram banks asking for register access
`timescale 1ns/10ps
module msc_unit_model (
   input logic clk,
   input logic ramIdle,
   output logic [7:0] unitAccessReq
);
   initial unitAccessReq = 8'h00;
   // ram requests drop while idle so a bank is never stopped mid access
   always @(posedge clk) unitAccessReq <= {ramIdle ? 3'h0 : 3'h7, 5'h1F};
endmodule

/* File: testbench/tb.sv */
// testbench: reset values, stop bits, reserved bits and access gating
`timescale 1ns/10ps
module tb;
   logic clk = 0, rst_n = 0, regWrite = 0, regRead = 0, ramIdle = 0;
   logic [1:0] regAddr = 0;
   logic [15:0] regWrData = 0, regRdData;
   logic [7:0] unitAccessReq, unitAccessGrant;
   logic pulseGenStop, serial4Stop, serial2Stop, serial1Stop, serial0Stop;
   logic [2:0] ramBankStop;
   int fail_count = 0, check_count = 0;
   msc_module_stop_ctrl uut (
      .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .unitAccessReq(unitAccessReq), .unitAccessGrant(unitAccessGrant),
      .pulseGenStop(pulseGenStop), .serial4Stop(serial4Stop), .serial2Stop(serial2Stop),
      .serial1Stop(serial1Stop), .serial0Stop(serial0Stop), .ramBankStop(ramBankStop)
   );
   msc_unit_model pm (.clk(clk), .ramIdle(ramIdle), .unitAccessReq(unitAccessReq));
   initial forever #12.5 clk = ~clk;
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task wr(input logic [1:0] a, input logic [15:0] v);
      regAddr <= a;
      regWrData <= v;
      regWrite <= 1;
      @(posedge clk);
      regWrite <= 0;
      @(posedge clk);
   endtask
   // outputs are looked at on the falling edge, away from the edge that launches them
   task rd(input logic [1:0] a, input logic [15:0] e);
      regAddr <= a;
      regRead <= 1;
      @(posedge clk);
      regRead <= 0;
      @(negedge clk);
      chk("read", e, regRdData);
      @(posedge clk);
   endtask
   task stops(input logic [7:0] e);
      @(negedge clk);
      chk("stops", e, {pulseGenStop, serial4Stop, serial2Stop, serial1Stop, serial0Stop,
         ramBankStop});
      @(posedge clk);
   endtask
   task grant(input logic [7:0] e);
      @(negedge clk);
      chk("grant", e, unitAccessGrant);
      @(posedge clk);
   endtask
   task t_reset;
      rd(0, 16'hFFFF); rd(1, 16'hFF00); stops(8'hF8);
   endtask
   task t_regb;
      wr(0, 16'h9500); rd(0, 16'hFDFF); stops(8'hE8);
      grant(8'hE8);
      wr(0, 16'h0000); rd(0, 16'h68FF); stops(8'h00);
   endtask
   task t_regc;
      ramIdle <= 1; @(posedge clk); @(posedge clk);
      wr(1, 16'h00FD); rd(1, 16'hFF05); stops(8'h05);
      wr(2, 16'hFFFF); rd(2, 16'h0000); rd(1, 16'hFF05);
      wr(1, 16'h0000); ramIdle <= 0; rd(0, 16'h68FF);
      grant(8'hFF);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1; @(posedge clk);
      t_reset; t_regb; t_regc;
      print_verdict;
   end
   initial begin
      #100000; fail_count++; print_verdict;
   end
endmodule
